// *** src/cmes_params.svh ***
// Contract
// - out-of-sync plus enable raises service flag
// - control bit 7 enables timing cell receiver
// - control bits 15:8 read as zero
// - status bit 0 latches reference failure
// - failure with holdover field 01 drives output
// - status bit 1 latches transmit underrun
// - status bit 2 latches transmit overrun
// - status bit 3 latches receive underrun
// - status bit 4 latches receive overrun
// - status bit 5 latches cell loss when control bit 7 enables the receiver
// - status bit 6 set on entering out-of-sync
// - writing one clears status bit, zero keeps
// - status bit 15 is OR of 6:0
// - status bits 14:7 read as zero
// - master clock control resets to 00C0h
// - bit 0 enable gates reference failure
// - bit 1 enable gates transmit slips
// - bit 3 enable gates receive slips
// - bit 5 enable gates cell loss
`ifndef CMES_PARAMS_SVH
`define CMES_PARAMS_SVH

// register indices as printed, byte address is four times these
`define CMES_IDX_CTRL 20'h0_6080
`define CMES_IDX_STAT 20'h0_6082
`define CMES_IDX_MCG 20'h0_6090
`define CMES_ADDR_W 20

// control register fields
`define CMES_CTRL_W 8
`define CMES_CB_REF_IE 0
`define CMES_CB_STX_IE 1
`define CMES_CB_CNT_UPD 2
`define CMES_CB_SRX_IE 3
`define CMES_CB_LOSS_IE 5
`define CMES_CB_SYNC_IE 6
`define CMES_CB_RX_EN 7
`define CMES_CTRL_RST 8'h00

// status register fields
`define CMES_STAT_W 7
`define CMES_SB_REF 0
`define CMES_SB_TX_UND 1
`define CMES_SB_TX_OVR 2
`define CMES_SB_RX_UND 3
`define CMES_SB_RX_OVR 4
`define CMES_SB_LOSS 5
`define CMES_SB_SYNC 6
`define CMES_SB_ANY 15
`define CMES_STAT_RST 7'h00

// master clock generation control
`define CMES_MCG_RST 16'h00c0
`define CMES_MCG_HOLD_LO 9
`define CMES_MCG_HOLD_HI 10
`define CMES_HOLD_ACTIVE 2'h1

// bus answers
`define CMES_RESP_OKAY 2'h0
`define CMES_RESP_SLVERR 2'h2

`endif

// *** src/cmes_pkg.sv ***
`include "cmes_params.svh"

package cmes_pkg;

	typedef logic [`CMES_ADDR_W-1:0] cmes_addr_t;
	typedef logic [1:0] cmes_resp_t;

	typedef struct packed
	{
		logic [`CMES_CTRL_W-1:0] ctrl;
		logic [`CMES_STAT_W-1:0] status;
		logic [15:0] mcg;
		logic sync_prev;
		logic cnt_update;
		logic aw_got;
		logic w_got;
		cmes_addr_t awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		cmes_resp_t bresp;
		logic rvalid;
		logic [31:0] rdata;
		cmes_resp_t rresp;
	} cmes_state_s;

endpackage

// *** src/cmes_top.sv ***
// Register access over AXI4-Lite was chosen for this implementation.
`include "cmes_params.svh"

module cmes_top
(
	// clock and reset
	input wire logic clk,
	input wire logic reset,

	// axi4-lite write address
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire cmes_pkg::cmes_addr_t s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,

	// axi4-lite write data
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,

	// axi4-lite write response
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	output cmes_pkg::cmes_resp_t s_axi_bresp,

	// axi4-lite read address
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	input wire cmes_pkg::cmes_addr_t s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,

	// axi4-lite read data
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic [31:0] s_axi_rdata,
	output cmes_pkg::cmes_resp_t s_axi_rresp,

	// events from clock sub-modules, same clock, one-cycle pulses
	input wire logic ref_clock_fail,
	input wire logic stamp_tx_underrun,
	input wire logic stamp_tx_overrun,
	input wire logic stamp_rx_underrun,
	input wire logic stamp_rx_overrun,
	input wire logic timing_cell_loss,
	// cell tracker out-of-sync level
	input wire logic cell_out_of_sync,

	// controls and flags toward the device
	output logic timing_cell_rx_en,
	output logic timing_service_flag,
	output logic holdover_output,
	output logic counter_update,
	output logic [15:0] master_clock_ctrl
);
	import cmes_pkg::*;

	cmes_state_s q;
	cmes_state_s d;

	logic aw_hs;
	logic w_hs;
	logic ar_hs;
	logic do_wr;
	cmes_addr_t wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic [`CMES_STAT_W-1:0] events;
	logic [`CMES_STAT_W-1:0] clr;
	logic [`CMES_STAT_W-1:0] enables;
	logic [1:0] wr_sel;
	logic [1:0] rd_sel;
	logic [15:0] ctrl_word;

	// ------------------------------------------------------------------
	// register decode
	// ------------------------------------------------------------------

	// maps a byte address to a register code, 0 when unmapped
	function automatic logic [1:0] reg_sel(input cmes_addr_t a);
		logic [1:0] s;
		s = 2'h0;
		if (a == cmes_addr_t'(`CMES_IDX_CTRL << 2))
			s = 2'h1;
		else if (a == cmes_addr_t'(`CMES_IDX_STAT << 2))
			s = 2'h2;
		else if (a == cmes_addr_t'(`CMES_IDX_MCG << 2))
			s = 2'h3;
		return s;
	endfunction

	// merges byte lanes 0 and 1 into a 16-bit register
	function automatic logic [15:0] lane_merge(input logic [15:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [15:0] v;
		v = old;
		if (strb[0])
			v[7:0] = data[7:0];
		if (strb[1])
			v[15:8] = data[15:8];
		return v;
	endfunction

	// ------------------------------------------------------------------
	// bus handshakes
	// ------------------------------------------------------------------

	// readies drop while a response waits, so no second write can overtake it
	assign s_axi_awready = !q.aw_got && !q.bvalid;
	assign s_axi_wready = !q.w_got && !q.bvalid;
	assign s_axi_arready = !q.rvalid;
	assign aw_hs = s_axi_awvalid && s_axi_awready;
	assign w_hs = s_axi_wvalid && s_axi_wready;
	assign ar_hs = s_axi_arvalid && s_axi_arready;
	assign do_wr = (q.aw_got || aw_hs) && (q.w_got || w_hs);
	assign wr_addr = q.aw_got ? q.awaddr : s_axi_awaddr;
	assign wr_data = q.w_got ? q.wdata : s_axi_wdata;
	assign wr_strb = q.w_got ? q.wstrb : s_axi_wstrb;

	// ------------------------------------------------------------------
	// status events and sync edge
	// ------------------------------------------------------------------

	always_comb
	begin
		events = '0;
		events[`CMES_SB_REF] = ref_clock_fail;
		events[`CMES_SB_TX_UND] = stamp_tx_underrun;
		events[`CMES_SB_TX_OVR] = stamp_tx_overrun;
		events[`CMES_SB_RX_UND] = stamp_rx_underrun;
		events[`CMES_SB_RX_OVR] = stamp_rx_overrun;
		events[`CMES_SB_LOSS] = timing_cell_loss && q.ctrl[`CMES_CB_RX_EN];
		events[`CMES_SB_SYNC] = cell_out_of_sync && !q.sync_prev;
	end

	// ------------------------------------------------------------------
	// service flag enables
	// ------------------------------------------------------------------

	always_comb
	begin
		enables = '0;
		enables[`CMES_SB_REF] = q.ctrl[`CMES_CB_REF_IE];
		enables[`CMES_SB_TX_UND] = q.ctrl[`CMES_CB_STX_IE];
		enables[`CMES_SB_TX_OVR] = q.ctrl[`CMES_CB_STX_IE];
		enables[`CMES_SB_RX_UND] = q.ctrl[`CMES_CB_SRX_IE];
		enables[`CMES_SB_RX_OVR] = q.ctrl[`CMES_CB_SRX_IE];
		enables[`CMES_SB_LOSS] = q.ctrl[`CMES_CB_LOSS_IE];
		enables[`CMES_SB_SYNC] = q.ctrl[`CMES_CB_SYNC_IE];
	end

	// ------------------------------------------------------------------
	// register select
	// ------------------------------------------------------------------

	// each channel decodes its address once
	assign wr_sel = reg_sel(wr_addr);
	assign rd_sel = reg_sel(s_axi_araddr);
	// control word as the write leaves it, upper byte never kept
	assign ctrl_word = lane_merge({8'h00, q.ctrl}, wr_data, wr_strb);

	// ------------------------------------------------------------------
	// status clear
	// ------------------------------------------------------------------

	// only byte lane 0 carries clear bits, the rest of the word is ignored
	// write-one clear
	assign clr = (do_wr && wr_sel == 2'h2 && wr_strb[0])
		? wr_data[`CMES_STAT_W-1:0] : '0;

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------

	always_comb
	begin
		d = q;
		// tracker level is remembered so a persisting loss does not set again
		d.sync_prev = cell_out_of_sync;
		d.cnt_update = 1'b0;
		d.status = (q.status & ~clr) | events;

		if (aw_hs)
		begin
			d.aw_got = 1'b1;
			d.awaddr = s_axi_awaddr;
		end
		if (w_hs)
		begin
			d.w_got = 1'b1;
			d.wdata = s_axi_wdata;
			d.wstrb = s_axi_wstrb;
		end

		if (do_wr)
		begin
			d.aw_got = 1'b0;
			d.w_got = 1'b0;
			d.bvalid = 1'b1;
			d.bresp = `CMES_RESP_OKAY;
			case (wr_sel)
				2'h1:
				begin
					d.ctrl = ctrl_word[`CMES_CTRL_W-1:0];
					d.cnt_update = wr_strb[0] && wr_data[`CMES_CB_CNT_UPD];
				end
				2'h2:
				begin
					d.bresp = `CMES_RESP_OKAY;
				end
				2'h3:
				begin
					d.mcg = lane_merge(q.mcg, wr_data, wr_strb);
				end
				default:
				begin
					d.bresp = `CMES_RESP_SLVERR;
				end
			endcase
		end
		else if (q.bvalid && s_axi_bready)
		begin
			d.bvalid = 1'b0;
		end

		if (ar_hs)
		begin
			d.rvalid = 1'b1;
			d.rresp = `CMES_RESP_OKAY;
			d.rdata = '0;
			case (rd_sel)
				2'h1:
				begin
					d.rdata[`CMES_CTRL_W-1:0] = q.ctrl;
				end
				2'h2:
				begin
					d.rdata[`CMES_STAT_W-1:0] = q.status;
					d.rdata[`CMES_SB_ANY] = |q.status;
				end
				2'h3:
				begin
					d.rdata[15:0] = q.mcg;
				end
				default:
				begin
					d.rresp = `CMES_RESP_SLVERR;
				end
			endcase
		end
		else if (q.rvalid && s_axi_rready)
		begin
			d.rvalid = 1'b0;
		end

		if (reset)
		begin
			d = '0;
			d.ctrl = `CMES_CTRL_RST;
			d.status = `CMES_STAT_RST;
			d.mcg = `CMES_MCG_RST;
		end
	end

	// ------------------------------------------------------------------
	// state register
	// ------------------------------------------------------------------

	always_ff @(posedge clk)
	begin
		q <= d;
	end

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------

	assign s_axi_bvalid = q.bvalid;
	assign s_axi_bresp = q.bresp;
	assign s_axi_rvalid = q.rvalid;
	assign s_axi_rdata = q.rdata;
	assign s_axi_rresp = q.rresp;

	// ------------------------------------------------------------------
	// control outputs
	// ------------------------------------------------------------------

	assign timing_cell_rx_en = q.ctrl[`CMES_CB_RX_EN];
	assign timing_service_flag = |(q.status & enables);
	assign holdover_output = q.status[`CMES_SB_REF]
		&& q.mcg[`CMES_MCG_HOLD_HI:`CMES_MCG_HOLD_LO] == `CMES_HOLD_ACTIVE;
	assign counter_update = q.cnt_update;
	assign master_clock_ctrl = q.mcg;

endmodule

// *** sim/cmes_checker.sv ***
module cmes_checker
(
	// clock and reset
	input wire logic clk,
	input wire logic reset,
	// bus handshakes
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	// events and outputs
	input wire logic ref_clock_fail,
	input wire logic timing_cell_rx_en,
	input wire logic timing_service_flag,
	input wire logic holdover_output,
	input wire logic [15:0] master_clock_ctrl
);
	timeunit 1ns;
	timeprecision 1ps;
	logic quiet;
	// no write data is offered and no write response waits at the coming edge
	assign quiet = !s_axi_wvalid && !s_axi_bvalid;
	default clocking @(posedge clk);
	endclocking
	default disable iff (reset);
	sequence wr_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence rd_take;
		s_axi_arvalid && s_axi_arready;
	endsequence
	write_answer_a: assert property (wr_take |=> s_axi_bvalid)
		else $error("write not answered");
	read_answer_a: assert property (rd_take |=> s_axi_rvalid)
		else $error("read not answered");
	write_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while busy");
	read_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready)
		else $error("read taken while busy");
	reset_value_a: assert property ($fell(reset) |->
		master_clock_ctrl == 16'h00c0 && !timing_cell_rx_en && !timing_service_flag)
		else $error("bad value after reset");
	holdover_set_a: assert property (ref_clock_fail && quiet &&
		master_clock_ctrl[10:9] == 2'h1 |=> holdover_output)
		else $error("holdover not raised");
	holdover_keep_a: assert property (holdover_output && quiet |=> holdover_output)
		else $error("holdover dropped");
	flag_keep_a: assert property (timing_service_flag && quiet |=> timing_service_flag)
		else $error("service flag dropped");
	rx_en_keep_a: assert property (quiet |=> $stable(timing_cell_rx_en))
		else $error("receive enable moved");
	mcg_keep_a: assert property (quiet |=> $stable(master_clock_ctrl))
		else $error("clock control moved");
endmodule

// *** sim/clock_module_event_status_bench.sv ***
`include "cmes_params.svh"
module clock_module_event_status_bench import cmes_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int CTRL = `CMES_IDX_CTRL;
	localparam int STAT = `CMES_IDX_STAT;
	localparam int MCG = `CMES_IDX_MCG;
	logic clk, reset, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic timing_cell_rx_en, timing_service_flag, holdover_output, cell_out_of_sync;
	logic counter_update;
	cmes_addr_t s_axi_awaddr, s_axi_araddr;
	cmes_resp_t s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [15:0] master_clock_ctrl;
	logic [5:0] ev;
	logic [33:0] rq[$];
	cmes_resp_t bq[$];
	int fail_count = 0;
	int tests_run = 0;
	int cyc = 0;
	int upd_count = 0;
	int en[6] = '{0, 1, 1, 3, 3, 5};
	cmes_top i_dut
	(
		.clk, .reset, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_awprot(3'h0),
		.s_axi_wvalid, .s_axi_wready, .s_axi_wdata, .s_axi_wstrb(4'hf),
		.s_axi_bvalid, .s_axi_bready, .s_axi_bresp, .s_axi_arvalid, .s_axi_arready,
		.s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_rvalid, .s_axi_rready, .s_axi_rdata,
		.s_axi_rresp, .ref_clock_fail(ev[0]), .stamp_tx_underrun(ev[1]),
		.stamp_tx_overrun(ev[2]), .stamp_rx_underrun(ev[3]), .stamp_rx_overrun(ev[4]),
		.timing_cell_loss(ev[5]), .cell_out_of_sync, .timing_cell_rx_en,
		.timing_service_flag, .holdover_output, .counter_update, .master_clock_ctrl
	);
	task automatic complete_run(bit t);
		fail_count += t;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	task automatic check(string n, logic [33:0] e, logic [33:0] g);
		tests_run++;
		if (e !== g)
		begin
			fail_count++;
			$display("unexpected %s expected %h seen %h", n, e, g);
		end
	endtask
	task automatic wr(int a, logic [31:0] d, cmes_resp_t r = 2'h0);
		bq.push_back(r);
		s_axi_awaddr <= 20'(a * 4);
		s_axi_wdata <= d;
		s_axi_awvalid <= 1;
		s_axi_wvalid <= 1;
		do @(negedge clk); while (!s_axi_awready);
		@(posedge clk);
		s_axi_awvalid <= 0;
		s_axi_wvalid <= 0;
		do @(negedge clk); while (!s_axi_bvalid);
		@(posedge clk);
	endtask
	task automatic rd(int a, logic [31:0] d, cmes_resp_t r = 2'h0);
		rq.push_back({r, d});
		s_axi_araddr <= 20'(a * 4);
		s_axi_arvalid <= 1;
		do @(negedge clk); while (!s_axi_arready);
		@(posedge clk);
		s_axi_arvalid <= 0;
		do @(negedge clk); while (!s_axi_rvalid);
		@(posedge clk);
	endtask
	task automatic pulse(logic [5:0] e);
		ev <= e;
		@(posedge clk);
		ev <= 0;
		@(posedge clk);
	endtask
	task automatic outs(logic f, logic h, logic x);
		@(negedge clk);
		check("outs", 34'({f, h, x}),
			34'({timing_service_flag, holdover_output, timing_cell_rx_en}));
		@(posedge clk);
	endtask
	initial
	begin
		clk = 0;
		forever #2 clk = ~clk;
	end
	// results are matched in order against the notes of the driver
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
			complete_run(1);
		if (s_axi_rvalid && s_axi_rready)
			check("read", rq.pop_front(), {s_axi_rresp, s_axi_rdata});
		if (s_axi_bvalid && s_axi_bready)
			check("bresp", 34'(bq.pop_front()), 34'(s_axi_bresp));
		if (counter_update)
			upd_count <= upd_count + 1;
	end
	initial
	begin
		logic [31:0] d;
		void'($urandom(32'hec22));
		reset = 1;
		ev = 0;
		{s_axi_awvalid, s_axi_wvalid, s_axi_arvalid, cell_out_of_sync} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		{s_axi_bready, s_axi_rready} = 2'h3;
		repeat (10) @(posedge clk);
		reset <= 0;
		@(posedge clk);
		rd(CTRL, 0);
		rd(STAT, 0);
		rd(MCG, 32'h00c0);
		rd(CTRL + 1, 0, `CMES_RESP_SLVERR);
		wr(CTRL + 1, 32'hffff, `CMES_RESP_SLVERR);
		d = $urandom() & 32'hffff_f9ff;
		wr(MCG, d);
		rd(MCG, {16'h0, d[15:0]});
		wr(CTRL, 32'hffff);
		rd(CTRL, 32'h00ff);
		outs(0, 0, 1);
		for (int i = 0; i < 6; i++)
		begin
			wr(CTRL, 32'h80);
			pulse(6'(1 << i));
			outs(0, 0, 1);
			wr(CTRL, 32'h80 | (1 << en[i]));
			outs(1, 0, 1);
			wr(STAT, 0);
			rd(STAT, 32'h8000 | (1 << i));
			wr(STAT, 1 << i);
			outs(0, 0, 1);
		end
		wr(CTRL, 32'h20);
		pulse(6'h20);
		rd(STAT, 0);
		wr(CTRL, 32'h40);
		cell_out_of_sync <= 1;
		@(posedge clk);
		outs(1, 0, 0);
		rd(STAT, 32'h8040);
		wr(STAT, 32'h40);
		rd(STAT, 0);
		cell_out_of_sync <= 0;
		wr(MCG, 32'h0200);
		pulse(6'h01);
		outs(0, 1, 0);
		wr(STAT, 1);
		outs(0, 0, 0);
		fork
			wr(STAT, 32'h4);
			pulse(6'h04);
		join
		rd(STAT, 32'h8004);
		reset <= 1;
		repeat (2) @(posedge clk);
		reset <= 0;
		@(posedge clk);
		rd(MCG, 32'h00c0);
		rd(STAT, 0);
		repeat (2) @(posedge clk);
		// only the write of all ones to control sets the update bit
		check("update", 34'(1), 34'(upd_count));
		complete_run(0);
	end
endmodule
bind cmes_top cmes_checker u_chk
(
	.clk, .reset, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .ref_clock_fail,
	.timing_cell_rx_en, .timing_service_flag, .holdover_output, .master_clock_ctrl
);
